// ### rtl/boot_loader_defines.svh
// Functional notes
// - reset maps ROM over lowest 4K reads
// - overlay writes still reach underlying RAM
// - lower 32K is plain unbanked RAM
// - upper addresses banked by bank select line
// - bank window size depends on processor variant
// - reset holds off-board drivers quiet
// - first action: outputs low, clocks, converters off
// - zero lower memory before accepting records
// - scrub leaves banked upper memory untouched
// - poll input; two discrete bits interpreted
// - sleep bit zero means reduced clock rate
// - awake plus maintenance applies probe power, bias
// - write record only after all checks pass
// - other-kind commands discarded, no write, no error flag
// - bulk store records handled like spacecraft records
// - valid load end record starts handoff
// - workspace writes silently dropped
// - handoff needs marker text at marker address
// - block checksum valid: complement byte, jump
// - handoff sets ports, drives overlay-off bit
// - copy first 64 bytes to debug area
// - secondary path re-enables overlay, returns to ROM
// - load reset record clears errors and sequence
`ifndef BOOT_LOADER_DEFINES_SVH
`define BOOT_LOADER_DEFINES_SVH
`define ROM_TOP         16'h0FFF
`define LOWER_TOP       16'h7FFF
`define WORK_LO         16'h7C00
`define WORK_HI         16'h7EFF
`define BLOCK_BASE      16'h7F00
`define MARKER_ADDR     16'h7F06
`define MARKER_LEN      5'd12
`define CSUM_ADDR       16'h7F3E
`define BLOCK_LEN       7'd64
`define DEBUG_BASE      16'h7F40
`define COPY_LEN        7'd64
`define VARIANT_LOW     2'd0
`define VARIANT_HIGH    2'd1
`define VARIANT_COMP    2'd2
`define BANK16_LO       16'h8000
`define BANK16_HI       16'hBFFF
`define SLEEP_BIT       1
`define MAINT_BIT       0
`define CSUM_GOOD       8'h00
`endif

// ### rtl/boot_loader_pkg.sv
package boot_loader_pkg;
	typedef enum logic [1:0] {
		RECORD_LOAD,
		RECORD_END,
		RECORD_RESET,
		RECORD_OTHER
	} record_kind_type;

	typedef struct packed {
		record_kind_type kind;
		logic [7:0]      recordSeq;
		logic [15:0]     address;
		logic [7:0]      data;
		logic            patternOk;
		logic            checksumOk;
	} load_record_type;

	typedef struct packed {
		logic        write;
		logic        read;
		logic [15:0] address;
		logic [7:0]  data;
	} mem_access_type;
endpackage

// ### rtl/address_mapper.sv
`timescale 1ns/10ps
`default_nettype none
`include "boot_loader_defines.svh"
// address decode: ROM overlay, lower RAM, banked upper window
module address_mapper
(
	// access
	input  wire boot_loader_pkg::mem_access_type access,
	input  wire logic                            overlayOn,
	input  wire logic                            bankSelectLine,
	input  wire logic [1:0]                      variant,
	// selects
	output logic                                 romRead,
	output logic                                 ramEnable,
	output logic                                 ramWrite,
	output logic [16:0]                          ramAddress
);
	import boot_loader_pkg::*;

	logic lowerHalf;
	logic banked;

	assign lowerHalf = access.address <= `LOWER_TOP;
	// which upper addresses are banked per variant
	always_comb
	begin
		case (variant)
			`VARIANT_LOW: banked = access.address >= `BANK16_LO &&
				access.address <= `BANK16_HI;
			`VARIANT_HIGH: banked = !lowerHalf;
			default: banked = 1'b0;
		endcase
	end
	// reads of low 4K come from ROM while overlaid
	assign romRead = overlayOn && access.read &&
		access.address <= `ROM_TOP;
	// RAM suppressed only for overlaid reads
	assign ramEnable = (access.read && !romRead) || access.write;
	assign ramWrite = access.write;
	// bank bit extends upper addresses
	assign ramAddress = {banked & bankSelectLine, access.address};
endmodule
`default_nettype wire

// ### rtl/boot_download_loader.sv
`timescale 1ns/10ps
`default_nettype none
`include "boot_loader_defines.svh"
// reset-time memory map and download sequencer
module boot_download_loader
(
	// clock and reset
	input  wire logic                             clock,
	input  wire logic                             rst_n,
	// configuration
	input  wire logic [1:0]                       variant,
	input  wire logic                             warmRestartEnable,
	// spacecraft bus interface records and discretes
	input  wire logic                             recordValid,
	input  wire boot_loader_pkg::load_record_type recordIn,
	input  wire logic                             recordFromBulk,
	input  wire logic [7:0]                       discreteIn,
	input  wire logic                             warmRestartReq,
	// memory port
	output var boot_loader_pkg::mem_access_type   memAccess,
	input  wire logic [7:0]                       memReadData,
	output logic                                  romRead,
	output logic                                  ramEnable,
	output logic                                  ramWrite,
	output logic [16:0]                           ramAddress,
	// peripherals and status
	output logic                                  offBoardEnable,
	output logic [7:0]                            portA,
	output logic [7:0]                            portC,
	output logic                                  portAOut,
	output logic                                  portCOut,
	output logic                                  portBOut,
	output logic                                  receiverClockOn,
	output logic                                  converterPowerOn,
	output logic                                  fullRate,
	output logic                                  probePowerOn,
	output logic                                  probeBias10V,
	output logic                                  overlayOn,
	output logic                                  bankSelectLine,
	output logic                                  recordReady,
	output logic                                  loadError,
	output logic                                  handoffDone,
	output logic                                  handoffRefused,
	output logic [15:0]                           jumpAddress
);
	import boot_loader_pkg::*;

	typedef enum logic [3:0] {
		INIT_HW, SCRUB, POLL, WRITE_REC, CHECK_MARKER, SUM_BLOCK,
		READ_CSUM, WRITE_CSUM, SET_PORTS, COPY_READ, COPY_WRITE, RUNNING
	} state_type;

	state_type state_q;
	logic [15:0] addr_q;
	logic [6:0]  count_q;
	logic [7:0]  sum_q;
	logic [7:0]  copy_q;
	logic [7:0]  seq_q;
	logic        error_q;
	logic        overlay_q;
	logic [7:0]  discA_q;
	logic [7:0]  discB_q;
	load_record_type rec_q;
	logic        recordOk;
	logic        workspaceHit;
	logic [7:0]  markerChar;

	// marker text expected at the marker address
	always_comb
	begin
		case (count_q[3:0])
			4'd0: markerChar = 8'h42;
			4'd1: markerChar = 8'h4F;
			4'd2: markerChar = 8'h4F;
			4'd3: markerChar = 8'h54;
			4'd4: markerChar = 8'h20;
			4'd5: markerChar = 8'h42;
			4'd6: markerChar = 8'h4C;
			4'd7: markerChar = 8'h4F;
			4'd8: markerChar = 8'h43;
			4'd9: markerChar = 8'h4B;
			4'd10: markerChar = 8'h3A;
			default: markerChar = 8'h20;
		endcase
	end

	// discrete inputs come from off the board, two flops
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			{discB_q, discA_q} <= 16'h0000;
		else
			{discB_q, discA_q} <= {discA_q, discreteIn};
	end

	// record acceptance checks
	assign recordOk = rec_q.patternOk && rec_q.checksumOk &&
		rec_q.recordSeq == seq_q && !error_q;
	assign workspaceHit = rec_q.address >= `WORK_LO &&
		rec_q.address <= `WORK_HI;
	assign recordReady = state_q == POLL;

	// main sequencer
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= INIT_HW;
			addr_q <= 16'h0000;
			count_q <= 7'd0;
			sum_q <= 8'h00;
			copy_q <= 8'h00;
			seq_q <= 8'h00;
			error_q <= 1'b0;
			overlay_q <= 1'b1;
			rec_q <= '0;
			handoffDone <= 1'b0;
			handoffRefused <= 1'b0;
			jumpAddress <= 16'h0000;
			portA <= 8'h00;
			portC <= 8'h00;
			portAOut <= 1'b0;
			portCOut <= 1'b0;
			portBOut <= 1'b0;
		end
		else
		begin
			case (state_q)
				INIT_HW:
				begin
					// outputs low, ports quiet
					portA <= 8'h00;
					portC <= 8'h00;
					addr_q <= 16'h0000;
					state_q <= SCRUB;
				end
				SCRUB:
				begin
					// lower memory only, upper banks kept
					addr_q <= addr_q + 16'h0001;
					if (addr_q == `LOWER_TOP)
						state_q <= POLL;
				end
				POLL:
				begin
					if (recordValid)
					begin
						// bulk store and spacecraft alike
						rec_q <= recordIn;
						state_q <= WRITE_REC;
					end
				end
				WRITE_REC:
				begin
					state_q <= POLL;
					case (rec_q.kind)
						RECORD_RESET:
						begin
							error_q <= 1'b0;
							seq_q <= 8'h00;
						end
						RECORD_LOAD:
						begin
							if (recordOk)
								seq_q <= seq_q + 8'h01;
							else
								error_q <= 1'b1;
						end
						RECORD_END:
						begin
							if (recordOk)
							begin
								handoffRefused <= 1'b0;
								count_q <= 7'd0;
								addr_q <= `MARKER_ADDR;
								state_q <= CHECK_MARKER;
							end
							else
								error_q <= 1'b1;
						end
						default: ;
					endcase
				end
				CHECK_MARKER:
				begin
					if (memReadData != markerChar)
					begin
						handoffRefused <= 1'b1;
						state_q <= POLL;
					end
					else if (count_q == {2'b00, `MARKER_LEN} - 7'd1)
					begin
						count_q <= 7'd0;
						sum_q <= 8'h00;
						addr_q <= `BLOCK_BASE;
						state_q <= SUM_BLOCK;
					end
					else
					begin
						count_q <= count_q + 7'd1;
						addr_q <= addr_q + 16'h0001;
					end
				end
				SUM_BLOCK:
				begin
					sum_q <= sum_q + memReadData;
					addr_q <= addr_q + 16'h0001;
					count_q <= count_q + 7'd1;
					if (count_q == `BLOCK_LEN - 7'd1)
					begin
						addr_q <= `CSUM_ADDR;
						state_q <= READ_CSUM;
					end
				end
				READ_CSUM:
				begin
					copy_q <= ~memReadData;
					if (sum_q == `CSUM_GOOD)
						state_q <= WRITE_CSUM;
					else
					begin
						handoffRefused <= 1'b1;
						state_q <= POLL;
					end
				end
				WRITE_CSUM:
				begin
					jumpAddress <= `BLOCK_BASE;
					state_q <= SET_PORTS;
				end
				SET_PORTS:
				begin
					portAOut <= 1'b1;
					portCOut <= 1'b1;
					portBOut <= 1'b0;
					portC <= 8'h00;
					portA <= 8'h80;
					overlay_q <= 1'b0;
					addr_q <= 16'h0000;
					count_q <= 7'd0;
					state_q <= COPY_READ;
				end
				COPY_READ:
				begin
					copy_q <= memReadData;
					state_q <= COPY_WRITE;
				end
				COPY_WRITE:
				begin
					addr_q <= addr_q + 16'h0001;
					count_q <= count_q + 7'd1;
					state_q <= COPY_READ;
					if (count_q == `COPY_LEN - 7'd1)
					begin
						handoffDone <= 1'b1;
						jumpAddress <= 16'h0000;
						state_q <= RUNNING;
					end
				end
				RUNNING:
				begin
					if (warmRestartReq && warmRestartEnable)
					begin
						overlay_q <= 1'b1;
						portA <= 8'h00;
						jumpAddress <= 16'h0000;
						handoffDone <= 1'b0;
						state_q <= POLL;
					end
				end
				default: state_q <= INIT_HW;
			endcase
		end
	end

	// memory access driven per state
	always_comb
	begin
		memAccess = '0;
		case (state_q)
			SCRUB:
			begin
				memAccess.write = 1'b1;
				memAccess.address = addr_q;
			end
			WRITE_REC:
			begin
				memAccess.write = rec_q.kind == RECORD_LOAD && recordOk &&
					!workspaceHit;
				memAccess.address = rec_q.address;
				memAccess.data = rec_q.data;
			end
			CHECK_MARKER, SUM_BLOCK, READ_CSUM, COPY_READ:
			begin
				memAccess.read = 1'b1;
				memAccess.address = addr_q;
			end
			WRITE_CSUM:
			begin
				memAccess.write = 1'b1;
				memAccess.address = `CSUM_ADDR;
				memAccess.data = copy_q;
			end
			COPY_WRITE:
			begin
				memAccess.write = 1'b1;
				memAccess.address = `DEBUG_BASE + addr_q;
				memAccess.data = copy_q;
			end
			default: memAccess = '0;
		endcase
	end

	// power and discrete handling
	assign fullRate = discB_q[`SLEEP_BIT];
	assign probePowerOn = fullRate && discB_q[`MAINT_BIT] &&
		state_q != INIT_HW;
	assign probeBias10V = probePowerOn;
	assign receiverClockOn = 1'b0;
	assign converterPowerOn = 1'b0;
	assign offBoardEnable = rst_n;
	assign overlayOn = overlay_q;
	assign loadError = error_q;
	assign bankSelectLine = 1'b0;

	address_mapper mapper
	(
		.access         (memAccess),
		.overlayOn      (overlay_q),
		.bankSelectLine (bankSelectLine),
		.variant        (variant),
		.romRead        (romRead),
		.ramEnable      (ramEnable),
		.ramWrite       (ramWrite),
		.ramAddress     (ramAddress)
	);
endmodule
`default_nettype wire

// ### test/boot_download_loader_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// property checks on the loader top ports
module boot_download_loader_asserts
(
	// clock and reset
	input wire logic                             clock,
	input wire logic                             rst_n,
	// memory port
	input wire boot_loader_pkg::mem_access_type  memAccess,
	input wire logic                             romRead,
	input wire logic                             ramWrite,
	input wire logic [16:0]                      ramAddress,
	// records
	input wire logic                             recordValid,
	input wire boot_loader_pkg::load_record_type recordIn,
	input wire logic                             recordReady,
	input wire logic                             loadError,
	// discretes and handoff
	input wire logic [7:0]                       discreteIn,
	input wire logic                             fullRate,
	input wire logic                             probePowerOn,
	input wire logic                             handoffDone,
	input wire logic                             overlayOn,
	input wire logic [7:0]                       portA
);
	import boot_loader_pkg::*;
	logic        taken;
	logic        goodRec;
	logic [15:0] upCount_q;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	// accepted record, and accepted with good flags
	assign taken = recordValid && recordReady;
	assign goodRec = taken && recordIn.patternOk && recordIn.checksumOk;
	// cycles since reset release, saturating
	always_ff @(posedge clock or negedge rst_n)
		if (!rst_n)
			upCount_q <= 16'h0000;
		else if (upCount_q != 16'hFFFF)
			upCount_q <= upCount_q + 16'h0001;
	property p_rom_read;
		romRead == (memAccess.read && overlayOn
			&& memAccess.address <= 16'h0FFF);
	endproperty
	a_rom_read: assert property (p_rom_read)
		else $error("rom read decode wrong");
	property p_low_write;
		memAccess.write && !memAccess.address[15] |->
			ramWrite && ramAddress == {1'b0, memAccess.address};
	endproperty
	a_low_write: assert property (p_low_write)
		else $error("low write missed ram");
	property p_scrub;
		upCount_q < 16'h8000 |-> !recordReady && (!memAccess.write
			|| (memAccess.data == 8'h00 && !memAccess.address[15]));
	endproperty
	a_scrub: assert property (p_scrub)
		else $error("scrub wrong or early ready");
	property p_workspace;
		goodRec && recordIn.kind == RECORD_LOAD
			&& recordIn.address inside {[16'h7C00:16'h7EFF]}
			|=> !memAccess.write;
	endproperty
	a_workspace: assert property (p_workspace)
		else $error("workspace written");
	property p_bad;
		taken && recordIn.kind == RECORD_LOAD && !recordIn.checksumOk
			|=> !memAccess.write ##1 loadError;
	endproperty
	a_bad: assert property (p_bad)
		else $error("bad record accepted");
	property p_other;
		taken && recordIn.kind == RECORD_OTHER
			|=> !memAccess.write && $stable(loadError);
	endproperty
	a_other: assert property (p_other)
		else $error("other command had effect");
	property p_clear;
		goodRec && recordIn.kind == RECORD_RESET |-> ##[1:2] !loadError;
	endproperty
	a_clear: assert property (p_clear)
		else $error("error flag not cleared");
	property p_rate;
		$stable(discreteIn[1]) [*4] |-> fullRate == discreteIn[1];
	endproperty
	a_rate: assert property (p_rate)
		else $error("clock rate wrong");
	property p_probe;
		$stable(discreteIn[1:0]) [*4]
			|-> probePowerOn == (discreteIn[1] && discreteIn[0]);
	endproperty
	a_probe: assert property (p_probe)
		else $error("probe power wrong");
	property p_handoff;
		$rose(handoffDone) |-> !overlayOn && portA == 8'h80;
	endproperty
	a_handoff: assert property (p_handoff)
		else $error("handoff ports wrong");
endmodule
`default_nettype wire

// ### test/mem_partner.sv
`timescale 1ns/10ps
`default_nettype none
// byte memory behind the loader memory port
module mem_partner
(
	// clock
	input  wire logic                            clock,
	// access
	input  wire boot_loader_pkg::mem_access_type memAccess,
	input  wire logic                            romRead,
	input  wire logic                            ramEnable,
	input  wire logic                            ramWrite,
	input  wire logic [16:0]                     ramAddress,
	// read return
	output logic [7:0]                           memReadData
);
	import boot_loader_pkg::*;
	logic [7:0] ram [131072];
	// rom pattern unlike ram; non-read cycles return the inverted low address byte
	always_comb
		if (romRead)
			memReadData = 8'hE7 ^ memAccess.address[7:0];
		else if (ramEnable && !ramWrite)
			memReadData = ram[ramAddress];
		else
			memReadData = ~memAccess.address[7:0];
	// byte write on the clock edge
	always @(posedge clock)
		if (ramEnable && ramWrite)
			ram[ramAddress] <= memAccess.data;
endmodule
`default_nettype wire

// ### test/boot_download_loader_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// self-checking bench for the boot download loader
module boot_download_loader_tb_top;
	import boot_loader_pkg::*;
	logic clock, rst_n, warmRestartEnable, recordValid, recordFromBulk;
	logic warmRestartReq, romRead, ramEnable, ramWrite, offBoardEnable;
	logic portAOut, portCOut, portBOut, receiverClockOn, converterPowerOn;
	logic fullRate, probePowerOn, probeBias10V, overlayOn, bankSelectLine;
	logic recordReady, loadError, handoffDone, handoffRefused;
	logic [1:0] variant;
	logic [7:0] discreteIn, memReadData, portA, portC;
	logic [16:0] ramAddress;
	logic [15:0] jumpAddress;
	load_record_type recordIn;
	mem_access_type memAccess;
	int errors, checksDone, cycles;
	boot_download_loader i_boot_download_loader (.*);
	mem_partner i_mem_partner (.*);
	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checksDone++;
		if (seen !== want)
		begin
			errors++;
			$display("wrong value at %0t: %h expected %h", $time, seen, want);
		end
	endtask
	// counts and verdict
	task automatic close_out();
		$display("checks %0d mismatches %0d", checksDone, errors);
		if (errors == 0 && checksDone > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// one record through the ready handshake
	task automatic send(input record_kind_type k, input logic [7:0] s,
		input logic [15:0] a, input logic [7:0] d, input logic good);
		@(posedge clock);
		while (recordReady !== 1'b1)
			@(posedge clock);
		recordValid <= 1'b1;
		recordIn <= '{k, s, a, d, good, good};
		@(posedge clock);
		recordValid <= 1'b0;
		repeat (3)
			@(posedge clock);
	endtask
	// quiet reset, then scrub of lower memory only
	task automatic t_reset();
		i_mem_partner.ram[0] = 8'hFF;
		i_mem_partner.ram[16'h7FFF] = 8'hFF;
		i_mem_partner.ram[17'h0_8000] = 8'hC3;
		i_mem_partner.ram[17'h1_FFFF] = 8'h3C;
		repeat (20)
			@(posedge clock);
		check(offBoardEnable, 1'b0);
		check(overlayOn, 1'b1);
		check({receiverClockOn, converterPowerOn, portA}, 10'h000);
		rst_n <= 1'b1;
		while (recordReady !== 1'b1)
			@(posedge clock);
		check(i_mem_partner.ram[0], 8'h00);
		check(i_mem_partner.ram[16'h7FFF], 8'h00);
		check(i_mem_partner.ram[17'h0_8000], 8'hC3);
		check(i_mem_partner.ram[17'h1_FFFF], 8'h3C);
		$display("reset test done");
	endtask
	// every combination of the two discrete bits
	task automatic t_discrete();
		for (int i = 0; i < 4; i++)
		begin
			discreteIn <= 8'hA8 | 8'(i);
			repeat (6)
				@(posedge clock);
			check(fullRate, i[1]);
			check(probePowerOn, i == 3);
			check(probeBias10V, i == 3);
		end
		$display("discrete test done");
	endtask
	// good, bulk, workspace, bad, foreign and out of order records
	task automatic t_records();
		send(RECORD_RESET, 8'h00, 16'h0000, 8'h00, 1'b1);
		send(RECORD_LOAD, 8'h00, 16'h0010, 8'h5A, 1'b1);
		check(i_mem_partner.ram[16'h0010], 8'h5A);
		recordFromBulk <= 1'b1;
		send(RECORD_LOAD, 8'h01, 16'h2000, 8'hA5, 1'b1);
		recordFromBulk <= 1'b0;
		check(i_mem_partner.ram[16'h2000], 8'hA5);
		send(RECORD_LOAD, 8'h02, 16'h7C10, 8'h77, 1'b1);
		check(i_mem_partner.ram[16'h7C10], 8'h00);
		check(loadError, 1'b0);
		send(RECORD_LOAD, 8'h03, 16'h0020, 8'h11, 1'b0);
		check(i_mem_partner.ram[16'h0020], 8'h00);
		check(loadError, 1'b1);
		send(RECORD_OTHER, 8'h04, 16'h0040, 8'h22, 1'b1);
		check(i_mem_partner.ram[16'h0040], 8'h00);
		send(RECORD_RESET, 8'h00, 16'h0000, 8'h00, 1'b1);
		check(loadError, 1'b0);
		send(RECORD_LOAD, 8'h05, 16'h0030, 8'h22, 1'b1);
		check(i_mem_partner.ram[16'h0030], 8'h00);
		check(loadError, 1'b1);
		$display("record test done");
	endtask
	// end record without the marker text
	task automatic t_refused();
		send(RECORD_RESET, 8'h00, 16'h0000, 8'h00, 1'b1);
		send(RECORD_END, 8'h00, 16'h0000, 8'h00, 1'b1);
		while (recordReady !== 1'b1)
			@(posedge clock);
		check(handoffRefused, 1'b1);
		check({handoffDone, overlayOn}, 2'b01);
		$display("refused test done");
	endtask
	// full load with marker and checksum, then warm restart
	task automatic t_handoff();
		string m;
		logic [7:0] sum;
		m = "BOOT BLOCK: ";
		sum = 8'h00;
		send(RECORD_RESET, 8'h00, 16'h0000, 8'h00, 1'b1);
		for (int i = 0; i < 12; i++)
		begin
			send(RECORD_LOAD, 8'(i), 16'h7F06 + 16'(i), m[i], 1'b1);
			sum = sum + m[i];
		end
		// marker in place but block sum not yet zero
		send(RECORD_END, 8'h0C, 16'h0000, 8'h00, 1'b1);
		while (recordReady !== 1'b1)
			@(posedge clock);
		check({handoffRefused, overlayOn}, 2'b11);
		send(RECORD_LOAD, 8'h0C, 16'h7F3E, 8'h00 - sum, 1'b1);
		send(RECORD_END, 8'h0D, 16'h0000, 8'h00, 1'b1);
		while (handoffDone !== 1'b1)
			@(posedge clock);
		@(posedge clock);
		check(i_mem_partner.ram[16'h7F3E], 8'(~(8'h00 - sum)));
		check(jumpAddress, 16'h0000);
		check(handoffRefused, 1'b0);
		check({portA, portC, overlayOn}, 17'h1_0000);
		check({portAOut, portCOut, portBOut}, 3'b110);
		check(i_mem_partner.ram[16'h7F50], 8'h5A);
		warmRestartEnable <= 1'b1;
		warmRestartReq <= 1'b1;
		while (overlayOn !== 1'b1)
			@(posedge clock);
		check(jumpAddress, 16'h0000);
		check({handoffDone, portA}, 9'h000);
		$display("handoff test done");
	endtask
	// clock
	initial
	begin
		clock = 1'b0;
		forever
			#4 clock = ~clock;
	end
	// hang guard
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			errors++;
			close_out();
		end
	end
	// main sequence
	initial
	begin
		rst_n = 1'b0;
		variant = 2'd1;
		warmRestartEnable = 1'b0;
		warmRestartReq = 1'b0;
		recordValid = 1'b0;
		recordIn = '0;
		recordFromBulk = 1'b0;
		discreteIn = 8'h00;
		t_reset();
		t_discrete();
		t_records();
		t_refused();
		t_handoff();
		close_out();
	end
endmodule
bind boot_download_loader boot_download_loader_asserts
	i_boot_download_loader_asserts (.*);
`default_nettype wire
